// file: burst_sram_pkg.sv
/*
 * shared constants and carrier types for the flow-through burst memory.
 * assumes a single 20 MHz clock and pins already synchronous to it.
 */
`default_nettype none

package burst_sram_pkg;

    // organisation
    localparam int unsigned WORDS   = 1048576;
    localparam int unsigned ADDR_W  = 20;
    localparam int unsigned DATA_W  = 18;
    localparam int unsigned LANES   = 2;
    localparam int unsigned LANE_W  = 9;
    localparam int unsigned BURST_W = 2;

    // reset values of control state, and the burst count step
    localparam logic [ADDR_W-1:0]  ADDR_RESET  = 20'h00000;
    localparam logic [DATA_W-1:0]  DOUT_RESET  = 18'h00000;
    localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
    localparam logic [BURST_W-1:0] COUNT_STEP  = 2'h1;

    // synchronous bus command sampled on each rising edge
    typedef struct packed {
        logic             processor_addr_strobe_n;
        logic             controller_addr_strobe_n;
        logic             burst_advance_n;
        logic             global_write_n;
        logic             lane_write_enable_n;
        logic [LANES-1:0] lane_write_pair_n;
        logic             master_select_n;
        logic             select_high;
        logic             select_low_n;
    } bus_cmd_type;

endpackage

`default_nettype wire

// file: burst_counter.sv
/*
 * two-bit burst sequencer for the lowest address bits.
 * assumes load and advance are never high together.
 */
`timescale 1ns/1ns
`default_nettype none

module burst_counter
(
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                rstn,
    // control
    input  wire logic                                load,
    input  wire logic [burst_sram_pkg::BURST_W-1:0]  start_bits,
    input  wire logic                                advance,
    input  wire logic                                linear,
    // next low address bits
    output logic      [burst_sram_pkg::BURST_W-1:0]  addr_lo_d
);
    import burst_sram_pkg::*;

    logic [BURST_W-1:0] start_q;
    logic [BURST_W-1:0] start_d;
    logic [BURST_W-1:0] count_q;
    logic [BURST_W-1:0] count_d;

    always_comb
    begin
        start_d = start_q;
        count_d = count_q;
        if (load)
        begin
            start_d = start_bits;
            count_d = COUNT_RESET;
        end
        else if (advance)
        begin
            count_d = 2'(count_q + COUNT_STEP);
        end
        // linear wraps mod four, interleaved xors the beat
        if (linear)
            addr_lo_d = 2'(start_d + count_d);
        else
            addr_lo_d = start_d ^ count_d;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            start_q <= COUNT_RESET;
            count_q <= COUNT_RESET;
        end
        else
        begin
            start_q <= start_d;
            count_q <= count_d;
        end
    end

endmodule // burst_counter

`default_nettype wire

// file: lane_decode.sv
/*
 * write-lane decode: which byte lanes a sampled command writes.
 * assumes inputs are already qualified by the caller.
 */
`timescale 1ns/1ns
`default_nettype none

module lane_decode
(
    // sampled write controls
    input  wire logic                              global_write_n,
    input  wire logic                              lane_write_enable_n,
    input  wire logic [burst_sram_pkg::LANES-1:0]  lane_write_pair_n,
    // lanes to write
    output logic      [burst_sram_pkg::LANES-1:0]  lane_mask
);
    import burst_sram_pkg::*;

    genvar i;
    generate
        for (i = 0; i < LANES; i++)
        begin : g_lane
            // global write overrides lanes; all lanes idle means read
            assign lane_mask[i] = !global_write_n ||
                (!lane_write_enable_n && !lane_write_pair_n[i]);
        end
    endgenerate

endmodule // lane_decode

`default_nettype wire

// file: burst_sram.sv
/*
 * flow-through synchronous burst memory, 1M words of two 9-bit lanes.
 * assumes bus pins are synchronous to ref_clk; output enable and sleep
 * act without the clock; the burst order strap is static.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - 1M words of 18 bits, two lanes
// - processor strobe with selects loads address
// - read data flows from registered address
// - advance ignored on processor strobe edge
// - advance only with both strobes high
// - strap high interleaved, low linear order
// - global write writes all 18 bits
// - lane writes need lane enable low
// - lane writes ignored on processor strobe edge
// - lane write disables outputs, captures data
// - write burst advances with advance low
// - controller strobe start samples writes immediately
// - selected only with all three enables
// - second enable high-true, third low-true
// - drive data only when enabled and reading
// - no lane active means a read
// - sleep deselects and keeps contents
module burst_sram
(
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                rstn,
    // synchronous bus
    input  wire burst_sram_pkg::bus_cmd_type         cmd,
    input  wire logic [burst_sram_pkg::ADDR_W-1:0]   address,
    // data pins split into three signals
    input  wire logic [burst_sram_pkg::DATA_W-1:0]   dq_in,
    output logic      [burst_sram_pkg::DATA_W-1:0]   dq_out,
    output logic                                     dq_oe,
    // asynchronous and static controls
    input  wire logic                                output_enable_n,
    input  wire logic                                sleep_request,
    input  wire logic                                burst_order_strap_n
);
    import burst_sram_pkg::*;

    // storage, no reset: contents survive sleep
    logic [DATA_W-1:0] mem_q [WORDS];

    logic              sel_all;
    logic              p_start;
    logic              c_start;
    logic              p_load;
    logic              c_load;
    logic              cont;
    logic              advance;
    logic              deselect;
    logic [LANES-1:0]  lane_mask;
    logic [LANES-1:0]  write_mask;
    logic [BURST_W-1:0] addr_lo_d;

    logic              active_q;
    logic              active_d;
    logic              read_q;
    logic              read_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;

    // start and continue decode
    always_comb
    begin
        sel_all = !cmd.master_select_n && cmd.select_high &&
                  !cmd.select_low_n;
        // master select gates the processor strobe only
        p_start = !cmd.processor_addr_strobe_n &&
                  !cmd.master_select_n && !sleep_request;
        c_start = !cmd.controller_addr_strobe_n && !p_start &&
                  !sleep_request;
        p_load  = p_start && sel_all;
        c_load  = c_start && sel_all;
        deselect = sleep_request || ((p_start || c_start) && !sel_all);
        cont    = active_q && cmd.processor_addr_strobe_n &&
                  cmd.controller_addr_strobe_n && !sleep_request;
        // never on a processor strobe edge, since cont needs it high
        advance = cont && !cmd.burst_advance_n;
    end

    lane_decode u_lane_decode
    (
        .global_write_n      (cmd.global_write_n),
        .lane_write_enable_n (cmd.lane_write_enable_n),
        .lane_write_pair_n   (cmd.lane_write_pair_n),
        .lane_mask           (lane_mask)
    );

    // lanes ignored on processor start, taken on controller start
    assign write_mask = (c_load || cont) ? lane_mask : '0;

    burst_counter u_burst_counter
    (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .load       (p_load || c_load),
        .start_bits (address[BURST_W-1:0]),
        .advance    (advance),
        .linear     (!burst_order_strap_n),
        .addr_lo_d  (addr_lo_d)
    );

    // access state
    always_comb
    begin
        active_d = active_q;
        addr_d   = addr_q;
        if (deselect)
            active_d = 1'b0;
        else if (p_load || c_load)
        begin
            active_d = 1'b1;
            addr_d   = {address[ADDR_W-1:BURST_W], addr_lo_d};
        end
        else if (advance)
            addr_d = {addr_q[ADDR_W-1:BURST_W], addr_lo_d};
        // a sampled lane write ends the read at once
        read_d = active_d && (write_mask == '0);
        // register the addressed word on the same edge: flow-through
        dout_d = read_d ? mem_q[addr_d] : dout_q;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_q <= 1'b0;
            read_q   <= 1'b0;
            addr_q   <= ADDR_RESET;
            dout_q   <= DOUT_RESET;
        end
        else
        begin
            active_q <= active_d;
            read_q   <= read_d;
            addr_q   <= addr_d;
            dout_q   <= dout_d;
        end
    end

    // lane writes straight into the array at the beat address;
    // one process keeps the array single-driven
    always_ff @(posedge ref_clk)
    begin
        for (int ln = 0; ln < LANES; ln++)
        begin
            if (write_mask[ln] && active_d)
                mem_q[addr_d][ln*LANE_W +: LANE_W] <=
                    dq_in[ln*LANE_W +: LANE_W];
        end
    end

    assign dq_out = dout_q;
    // output enable acts without the clock, so this stays a gate
    assign dq_oe = read_q && !output_enable_n && !sleep_request;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_proc_load;
        p_load;
    endsequence

    sequence s_step;
        cont && !cmd.burst_advance_n;
    endsequence

    sequence s_hold;
        cont && cmd.burst_advance_n;
    endsequence

    proc_addr_load_a: assert property (s_proc_load |=> active_q &&
        addr_q == $past(address))
        else $error("processor strobe did not load the address");

    adv_ignored_a: assert property (s_proc_load ##0 !cmd.burst_advance_n
        |=> addr_q[1:0] == $past(address[1:0]))
        else $error("advance acted on a start edge");

    linear_step_a: assert property (s_step ##0 !burst_order_strap_n
        |=> addr_q[1:0] == 2'($past(addr_q[1:0]) + 2'h1))
        else $error("linear burst step wrong");

    burst_hold_a: assert property (s_hold |=> $stable(addr_q))
        else $error("address moved without advance");

    flow_read_a: assert property (read_q |-> dq_out == mem_q[addr_q])
        else $error("read data not from registered address");

    global_write_a: assert property (cont && !cmd.global_write_n
        |=> mem_q[$past(addr_d)] == $past(dq_in))
        else $error("global write missed bits");

    lane_ignore_a: assert property (s_proc_load |=> read_q)
        else $error("lane write taken on processor strobe edge");

    write_oe_a: assert property (write_mask != '0 && active_d
        |=> !dq_oe)
        else $error("outputs driven during write");

    ctrl_write_a: assert property (c_load && !cmd.global_write_n
        |=> !read_q)
        else $error("controller start write not sampled");

    master_block_a: assert property (!cmd.processor_addr_strobe_n &&
        cmd.master_select_n && cmd.controller_addr_strobe_n &&
        !active_q |=> !active_q)
        else $error("master select failed to block start");

    sleep_deselect_a: assert property (sleep_request
        |=> !active_q && !read_q)
        else $error("sleep did not deselect");

endmodule // burst_sram

`default_nettype wire

// file: ctl_model.sv
/*
 * controller model that drives the burst memory bus one beat per clock.
 * assumes the bench calls beat back to back from a single process.
 */
`timescale 1ns/1ns
`default_nettype none

module ctl_model
(
    // clock
    input  wire logic                               ref_clk,
    // bus towards the memory
    output var burst_sram_pkg::bus_cmd_type          cmd,
    output logic [burst_sram_pkg::ADDR_W-1:0]        address,
    output logic [burst_sram_pkg::DATA_W-1:0]        dq_in,
    output logic                                     output_enable_n
);
    import burst_sram_pkg::*;

    initial
    begin
        cmd             = bus_cmd_type'(10'h3fa);
        address         = '0;
        dq_in           = '0;
        output_enable_n = 1'b0;
    end

    // rude flips output enable: low on a write, high on a read
    task automatic beat(input bus_cmd_type c, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic rude);
        bus_cmd_type cc;
        logic wr;
        cc = c;
        // controller start keeps processor strobe high
        if (!c.controller_addr_strobe_n)
            cc.processor_addr_strobe_n = 1'b1;
        wr = (!cc.global_write_n
              | (!cc.lane_write_enable_n & ~&cc.lane_write_pair_n))
             & (cc.processor_addr_strobe_n | cc.master_select_n);
        @(negedge ref_clk);
        cmd <= cc;
        address <= a;
        // released data never shows the last value
        dq_in <= wr ? d : ~dq_in;
        output_enable_n <= wr ? !rude : rude;
        @(posedge ref_clk);
        #1;
    endtask
endmodule // ctl_model

`default_nettype wire

// file: tb_top.sv
/*
 * self-checking bench for the flow-through burst memory.
 * assumes the controller model drives the bus; the bench checks read back.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import burst_sram_pkg::*;

    localparam logic [9:0] IDL = 10'h3fa, PS = 10'h200, CS = 10'h100;
    localparam logic [9:0] AD = 10'h080, GW = 10'h040, LE = 10'h020;
    localparam logic [9:0] L1 = 10'h010, L0 = 10'h008, MS = 10'h004;
    localparam logic [9:0] SH = 10'h002, SL = 10'h001;
    localparam logic [ADDR_W-1:0] X = 20'h00100, Y = 20'h00200;

    logic               ref_clk;
    logic               rstn;
    logic               sleep_request;
    logic               burst_order_strap_n;
    logic               output_enable_n;
    logic               dq_oe;
    logic [ADDR_W-1:0]  address;
    logic [DATA_W-1:0]  dq_in;
    logic [DATA_W-1:0]  dq_out;
    bus_cmd_type        cmd;
    int                 bad_count;
    int                 samples_checked;

    ctl_model u_ctl_model (.ref_clk(ref_clk), .cmd(cmd), .address(address),
        .dq_in(dq_in), .output_enable_n(output_enable_n));
    burst_sram u_burst_sram (.ref_clk(ref_clk), .rstn(rstn), .cmd(cmd),
        .address(address), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .burst_order_strap_n(burst_order_strap_n));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return a[DATA_W-1:0] ^ 18'h2d2d2;
    endfunction

    task automatic b(input logic [9:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic r);
        u_ctl_model.beat(bus_cmd_type'(c), a, d, r);
    endtask

    task automatic chk(input logic [DATA_W-1:0] e, input logic o);
        samples_checked++;
        if (dq_out !== e || dq_oe !== o)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h/%b want %h/%b", $time, dq_out, dq_oe,
                     e, o);
        end
    endtask

    task automatic chk_oe(input logic o);
        samples_checked++;
        if (dq_oe !== o)
        begin
            bad_count++;
            $display("[FAIL] %0t drive %b want %b", $time, dq_oe, o);
        end
    endtask

    // four-beat write then read, wrap from a nonzero start
    task automatic burst_order(input logic s);
        logic [1:0]        lo;
        logic [ADDR_W-1:0] a;
        burst_order_strap_n = s;
        for (int k = 0; k < 8; k++)
        begin
            lo = s ? (2'h1 ^ k[1:0]) : (2'h3 + k[1:0]);
            a = {18'h0abc0 | s, lo};
            if (k < 4)
                b(((k == 0) ? (IDL ^ CS) : (IDL ^ AD)) ^ GW, a, pat(a), 0);
            else
                b((k == 4) ? (IDL ^ PS ^ AD) : (IDL ^ AD), a, '0, 0);
            if (k < 4)
                chk_oe(1'b0);
            else
                chk(pat(a), 1'b1);
        end
    endtask

    task automatic lanes;
        b(IDL ^ CS ^ GW, X, 18'h3ffff, 0);
        b(IDL ^ CS ^ LE ^ L1, X, 18'h00000, 0);
        b(IDL ^ CS ^ L0, X, 18'h00000, 0);
        chk(18'h001ff, 1'b1);
        b(IDL ^ PS ^ GW ^ LE ^ L0, X, 18'h00000, 0);
        chk(18'h001ff, 1'b1);
        b(IDL ^ CS ^ LE ^ L0 ^ L1, X, 18'h15555, 1);
        chk_oe(1'b0);
        b(IDL ^ PS, X, '0, 0);
        chk(18'h15555, 1'b1);
    endtask

    task automatic selects;
        b(IDL ^ CS ^ MS, X, '0, 0);
        chk(18'h15555, 1'b0);
        b(IDL ^ PS ^ SH, X, '0, 0);
        chk_oe(1'b0);
        b(IDL ^ PS, X, '0, 0);
        b(IDL ^ PS ^ SL, X, '0, 0);
        chk_oe(1'b0);
        b(IDL ^ PS ^ MS, Y, '0, 0);
        chk_oe(1'b0);
        b(IDL ^ PS, X, '0, 0);
        b(IDL ^ PS ^ MS, Y, '0, 0);
        chk(18'h15555, 1'b1);
        b(IDL ^ PS, X, '0, 1);
        chk(18'h15555, 1'b0);
    endtask

    task automatic sleep_keep;
        sleep_request = 1'b1;
        b(IDL ^ PS, X, '0, 0);
        chk_oe(1'b0);
        sleep_request = 1'b0;
        b(IDL ^ PS, X, '0, 0);
        chk(18'h15555, 1'b1);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // a hang would otherwise never reach the verdict
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        bad_count++;
        close_out();
    end

    initial
    begin
        bad_count = 0;
        samples_checked = 0;
        rstn = 1'b0;
        sleep_request = 1'b0;
        burst_order_strap_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        chk(18'h00000, 1'b0);
        burst_order(1'b0);
        burst_order(1'b1);
        lanes();
        selects();
        sleep_keep();
        close_out();
    end
endmodule // tb_top

`default_nettype wire
